// file: shared/sgcp_pkg.sv
`default_nettype none

package sgcp_pkg;

  // configuration data path width
  localparam int unsigned CFG_DW = 8;

  // host I/O port addresses
  localparam logic [15:0] CFG_INDEX_PORT = 16'h002E;
  localparam logic [15:0] CFG_DATA_PORT  = 16'h002F;

  // key values written to the index port
  localparam logic [7:0] KEY_ENTER = 8'h87;
  localparam logic [7:0] KEY_EXIT  = 8'hAA;

  // logical device select index and device numbers
  localparam logic [7:0] LDN_INDEX    = 8'h07;
  localparam logic [7:0] LDN_GPIO     = 8'h07;
  localparam logic [7:0] LDN_EN_BANK  = 8'h09;

  // register indices
  localparam logic [7:0] REG_FUNC_EN  = 8'h30;
  localparam logic [7:0] REG_DIR      = 8'hE0;
  localparam logic [7:0] REG_DATA     = 8'hE1;
  localparam logic [7:0] REG_INV      = 8'hE2;

  // field position of the function enable
  localparam int unsigned FUNC_EN_BIT = 7;

  // reset values
  localparam logic [7:0] RST_IDX     = 8'h00;
  localparam logic [7:0] RST_LDN     = 8'h00;
  localparam logic [7:0] RST_FUNC_EN = 8'h00;
  localparam logic [7:0] RST_DIR     = 8'hFF;
  localparam logic [7:0] RST_DATA    = 8'h00;
  localparam logic [7:0] RST_INV     = 8'h00;

  // answer to a read while locked, and to an unmapped index
  localparam logic [7:0] RD_LOCKED   = 8'hFF;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // unlock sequencer states
  typedef enum logic [1:0] {
    ST_LOCKED,
    ST_KEY1,
    ST_OPEN
  } sgcp_lock_t;

endpackage

`default_nettype wire

// file: rtl/sgcp_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sgcp_sync2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second; nothing else reads it
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

// file: rtl/sgcp_gpio_port.sv
`timescale 1ns/1ps
`default_nettype none

module sgcp_gpio_port
  import sgcp_pkg::*;
(
  input  wire logic [15:0]       I_IO_ADDR,
  input  wire logic              I_MCLK,
  input  wire logic              I_RST_B,
  input  wire logic              I_IO_WR,
  input  wire logic              I_IO_RD,
  input  wire logic [CFG_DW-1:0] I_IO_WDATA,
  input  wire logic [CFG_DW-1:0] I_GPIO_PIN,
  output logic      [CFG_DW-1:0] O_IO_RDATA,
  output logic                   O_IO_RVALID,
  output logic      [CFG_DW-1:0] O_GPIO_OUT,
  output logic      [CFG_DW-1:0] O_GPIO_OE,
  output logic                   O_CFG_OPEN
);

  // port match, used for every strobe decode
  function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
    port_hit = (addr == port);
  endfunction

  sgcp_lock_t        lock_q;
  sgcp_lock_t        lock_d;
  logic [CFG_DW-1:0] idx_q;
  logic [CFG_DW-1:0] idx_d;
  logic [CFG_DW-1:0] ldn_q;
  logic [CFG_DW-1:0] ldn_d;
  logic [CFG_DW-1:0] func_en_q;
  logic [CFG_DW-1:0] func_en_d;
  logic [CFG_DW-1:0] dir_q;
  logic [CFG_DW-1:0] dir_d;
  logic [CFG_DW-1:0] data_q;
  logic [CFG_DW-1:0] data_d;
  logic [CFG_DW-1:0] inv_q;
  logic [CFG_DW-1:0] inv_d;
  logic [CFG_DW-1:0] rdata_q;
  logic [CFG_DW-1:0] rdata_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic [CFG_DW-1:0] pin_out_q;
  logic [CFG_DW-1:0] pin_out_d;
  logic [CFG_DW-1:0] pin_oe_q;
  logic [CFG_DW-1:0] pin_oe_d;
  logic              open_q;
  logic              open_d;
  logic [CFG_DW-1:0] pin_sync;
  logic [CFG_DW-1:0] pin_seen;
  logic [CFG_DW-1:0] data_view;
  logic              wr_idx;
  logic              wr_dat;
  logic              rd_idx;
  logic              rd_dat;
  logic              is_open;
  logic              gpio_sel;
  logic              bank_sel;

  // pins come from outside the clock domain
  sgcp_sync2 #(
    .WIDTH (CFG_DW)
  ) u_pin_sync (
    .i_clk   (I_MCLK),
    .i_rst_b (I_RST_B),
    .i_async (I_GPIO_PIN),
    .o_sync  (pin_sync)
  );

  // strobe decode of the two configuration ports
  assign wr_idx   = I_IO_WR && port_hit(I_IO_ADDR, CFG_INDEX_PORT);
  assign wr_dat   = I_IO_WR && port_hit(I_IO_ADDR, CFG_DATA_PORT);
  assign rd_idx   = I_IO_RD && port_hit(I_IO_ADDR, CFG_INDEX_PORT);
  assign rd_dat   = I_IO_RD && port_hit(I_IO_ADDR, CFG_DATA_PORT);
  assign is_open  = (lock_q == ST_OPEN);
  assign gpio_sel = (ldn_q == LDN_GPIO);
  assign bank_sel = (ldn_q == LDN_EN_BANK);

  // per-bit view of the data register as software reads it
  genvar gi;
  generate
    for (gi = 0; gi < CFG_DW; gi++)
    begin : g_bit
      assign pin_seen[gi]  = pin_sync[gi] ^ inv_q[gi];
      assign data_view[gi] = dir_q[gi] ? pin_seen[gi] : data_q[gi];
    end
  endgenerate

  // unlock sequencer and configuration registers
  always_comb
  begin
    lock_d    = lock_q;
    idx_d     = idx_q;
    ldn_d     = ldn_q;
    func_en_d = func_en_q;
    dir_d     = dir_q;
    data_d    = data_q;
    inv_d     = inv_q;
    unique case (lock_q)
      ST_LOCKED:
      begin
        // everything but the key is dropped while locked
        if (wr_idx && (I_IO_WDATA == KEY_ENTER))
          lock_d = ST_KEY1;
      end
      ST_KEY1:
      begin
        // the second key must follow directly; any other access restarts
        if (wr_idx && (I_IO_WDATA == KEY_ENTER))
          lock_d = ST_OPEN;
        else if (wr_idx || wr_dat || rd_idx || rd_dat)
          lock_d = ST_LOCKED;
      end
      ST_OPEN:
      begin
        if (wr_idx && (I_IO_WDATA == KEY_EXIT))
          lock_d = ST_LOCKED;
        else if (wr_idx)
          idx_d = I_IO_WDATA;
        if (wr_dat)
        begin
          if (idx_q == LDN_INDEX)
            ldn_d = I_IO_WDATA;
          else if (bank_sel && (idx_q == REG_FUNC_EN))
            func_en_d = I_IO_WDATA;
          else if (gpio_sel && (idx_q == REG_DIR))
            dir_d = I_IO_WDATA;
          else if (gpio_sel && (idx_q == REG_DATA))
            data_d = (data_q & dir_q) | (I_IO_WDATA & ~dir_q);
          else if (gpio_sel && (idx_q == REG_INV))
            inv_d = I_IO_WDATA;
        end
      end
      // the fourth code is unused; an upset lands back in the safe state
      default:
        lock_d = ST_LOCKED;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      lock_q    <= ST_LOCKED;
      idx_q     <= RST_IDX;
      ldn_q     <= RST_LDN;
      func_en_q <= RST_FUNC_EN;
      dir_q     <= RST_DIR;
      data_q    <= RST_DATA;
      inv_q     <= RST_INV;
    end
    else
    begin
      lock_q    <= lock_d;
      idx_q     <= idx_d;
      ldn_q     <= ldn_d;
      func_en_q <= func_en_d;
      dir_q     <= dir_d;
      data_q    <= data_d;
      inv_q     <= inv_d;
    end
  end

  // read answer and pin drivers, all registered
  always_comb
  begin
    rdata_d  = rdata_q;
    rvalid_d = rd_idx || rd_dat;
    if (rd_idx)
      rdata_d = is_open ? idx_q : RD_LOCKED;
    else if (rd_dat)
    begin
      if (!is_open)
        rdata_d = RD_LOCKED;
      else if (idx_q == LDN_INDEX)
        rdata_d = ldn_q;
      else if (bank_sel && (idx_q == REG_FUNC_EN))
        rdata_d = func_en_q;
      else if (gpio_sel && (idx_q == REG_DIR))
        rdata_d = dir_q;
      else if (gpio_sel && (idx_q == REG_DATA))
        rdata_d = data_view;
      else if (gpio_sel && (idx_q == REG_INV))
        rdata_d = inv_q;
      else
        rdata_d = RD_UNMAPPED;
    end
    // outgoing value flips through the inversion mask as well
    pin_out_d = data_q ^ inv_q;
    // pins float until the function is enabled, so boot never fights the board
    pin_oe_d  = ~dir_q & {CFG_DW{func_en_q[FUNC_EN_BIT]}};
    open_d    = (lock_d == ST_OPEN);
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      rdata_q   <= RD_UNMAPPED;
      rvalid_q  <= 1'b0;
      pin_out_q <= RST_DATA;
      pin_oe_q  <= '0;
      open_q    <= 1'b0;
    end
    else
    begin
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
      open_q    <= open_d;
    end
  end

  assign O_IO_RDATA  = rdata_q;
  assign O_IO_RVALID = rvalid_q;
  assign O_GPIO_OUT  = pin_out_q;
  assign O_GPIO_OE   = pin_oe_q;
  assign O_CFG_OPEN  = open_q;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_B);

  // second consecutive key opens configuration
  a_key_unlock: assert property (
    (lock_q == ST_KEY1) && wr_idx && (I_IO_WDATA == KEY_ENTER) |=> is_open ##1 O_CFG_OPEN)
    else $error("double key did not unlock");

  // one key alone never opens
  a_single_key: assert property (
    (lock_q == ST_LOCKED) && wr_idx && (I_IO_WDATA == KEY_ENTER) |=> !is_open)
    else $error("single key unlocked configuration");

  // exit key relocks
  a_exit_relock: assert property (
    is_open && wr_idx && (I_IO_WDATA == KEY_EXIT) |=> (lock_q == ST_LOCKED) ##1 !O_CFG_OPEN)
    else $error("exit key did not relock");

  // locked data writes change no configuration register
  a_locked_ignore: assert property (
    !is_open && wr_dat |=> $stable(dir_q) && $stable(data_q) && $stable(inv_q) && $stable(func_en_q)
                           && $stable(ldn_q))
    else $error("write accepted while locked");

  // locked reads answer the idle value
  a_locked_read: assert property (
    !is_open && (rd_idx || rd_dat) |=> O_IO_RVALID && (O_IO_RDATA == RD_LOCKED))
    else $error("locked read returned register data");

  // index port write loads the index
  a_index_load: assert property (
    is_open && wr_idx && (I_IO_WDATA != KEY_EXIT) |=> idx_q == $past(I_IO_WDATA))
    else $error("index port write lost");

  // device select follows the data written at index 07h
  a_device_select: assert property (
    is_open && wr_dat && (idx_q == LDN_INDEX) |=> ldn_q == $past(I_IO_WDATA))
    else $error("logical device not selected");

  // enable bit in bank 09h gates the drivers
  a_enable_gate: assert property (
    is_open && wr_dat && bank_sel && (idx_q == REG_FUNC_EN) && I_IO_WDATA[FUNC_EN_BIT]
      |=> func_en_q[FUNC_EN_BIT] ##1 (O_GPIO_OE == ~$past(dir_q)))
    else $error("function enable did not drive pins");

  // drivers follow direction: zero drives, one releases
  a_dir_drive: assert property (
    $past(func_en_q[FUNC_EN_BIT]) |-> O_GPIO_OE == ~$past(dir_q))
    else $error("direction does not steer output enable");

  // output bits take the written value
  a_out_write: assert property (
    is_open && wr_dat && gpio_sel && (idx_q == REG_DATA)
      |=> (data_q & ~$past(dir_q)) == ($past(I_IO_WDATA) & ~$past(dir_q)))
    else $error("output bit not written");

  // input bits keep their stored value on a write
  a_in_protect: assert property (
    is_open && wr_dat && gpio_sel && (idx_q == REG_DATA)
      |=> (data_q & $past(dir_q)) == ($past(data_q) & $past(dir_q)))
    else $error("input bit changed by write");

  // reading data mixes pins and stored bits through the mask
  a_data_read: assert property (
    is_open && rd_dat && gpio_sel && (idx_q == REG_DATA)
      |=> O_IO_RDATA == ((($past(pin_sync) ^ $past(inv_q)) & $past(dir_q)) | ($past(data_q) & ~$past(dir_q))))
    else $error("data read does not match pins");

  // pin value is data through the inversion mask
  a_out_polarity: assert property (
    ##1 1'b1 |-> O_GPIO_OUT == ($past(data_q) ^ $past(inv_q)))
    else $error("output polarity wrong");

  // no read strobe, no answer pulse
  a_rvalid_only: assert property (
    !(rd_idx || rd_dat) |=> !O_IO_RVALID)
    else $error("read answer without a read");

  // open index port read returns the held index
  a_index_read: assert property (
    is_open && rd_idx |=> O_IO_RVALID && (O_IO_RDATA == $past(idx_q)))
    else $error("index read wrong");

endmodule

`default_nettype wire

// file: tb/sgcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sgcp_host_model
  import sgcp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_rdata,
  input  wire logic        i_rvalid,
  output logic      [15:0] o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [7:0]  o_wdata
);
  // bus idle at time zero
  initial {o_addr, o_wr, o_rd, o_wdata} = '0;
  // write strobe; a released bus shows inverted values, never stale ones
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // read strobe; the answer is registered on the taking edge and sampled at the falling edge after it
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    ok = i_rvalid;
    d = i_rdata;
  endtask
  // two keys in a row open configuration
  task automatic unlock();
    wr(CFG_INDEX_PORT, KEY_ENTER);
    wr(CFG_INDEX_PORT, KEY_ENTER);
  endtask
  // index first, then data
  task automatic put(input logic [7:0] i, input logic [7:0] v);
    wr(CFG_INDEX_PORT, i);
    wr(CFG_DATA_PORT, v);
  endtask
  // read-modify-write so the other enable bits survive
  task automatic en_gpio(output logic [7:0] p, output logic ok);
    put(LDN_INDEX, LDN_EN_BANK);
    wr(CFG_INDEX_PORT, REG_FUNC_EN);
    rd(CFG_DATA_PORT, p, ok);
    wr(CFG_DATA_PORT, p | (8'h01 << FUNC_EN_BIT));
  endtask
endmodule

`default_nettype wire

// file: tb/tb_superio_gpio_config_port.sv
`timescale 1ns/1ps
`default_nettype none

module tb_superio_gpio_config_port
  import sgcp_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic [15:0] addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  pin;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [7:0]  gout;
  logic [7:0]  goe;
  logic        cfg_open;
  int          err_total;
  int          cmp_count;
  // device and its host-side partner
  sgcp_gpio_port uut (
    .I_IO_ADDR(addr), .I_MCLK(clk), .I_RST_B(rst_b), .I_IO_WR(wr), .I_IO_RD(rd),
    .I_IO_WDATA(wdata), .I_GPIO_PIN(pin), .O_IO_RDATA(rdata), .O_IO_RVALID(rvalid),
    .O_GPIO_OUT(gout), .O_GPIO_OE(goe), .O_CFG_OPEN(cfg_open)
  );
  sgcp_host_model host (
    .i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata)
  );
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // compare and count; case inequality so unknowns fail
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  // the one place that ends the run
  task automatic conclude();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // indexed read; a missing strobe spoils the value on purpose
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic       ok;
    host.wr(CFG_INDEX_PORT, idx);
    host.rd(CFG_DATA_PORT, d, ok);
    chk((ok === 1'b1) ? d : ~exp, exp, what);
  endtask
  // locked after reset; stray, broken and misplaced keys must not open
  task automatic t_keys();
    logic [7:0] d;
    logic       ok;
    chk({7'h00, cfg_open}, 8'h00, "open at reset");
    host.put(LDN_INDEX, LDN_GPIO);
    rdchk(REG_DIR, RD_LOCKED, "locked read");
    host.rd(CFG_INDEX_PORT, d, ok);
    chk((ok === 1'b1) ? d : 8'h00, RD_LOCKED, "locked index read");
    host.wr(16'h004E, KEY_ENTER);
    host.wr(16'h004E, KEY_ENTER);
    host.wr(CFG_INDEX_PORT, KEY_ENTER);
    host.rd(CFG_DATA_PORT, d, ok);
    chk((ok === 1'b1) ? d : 8'h00, RD_LOCKED, "read between keys");
    host.wr(CFG_INDEX_PORT, KEY_ENTER);
    host.wr(CFG_DATA_PORT, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h00, cfg_open}, 8'h00, "broken key");
    host.unlock();
    repeat (2) @(negedge clk);
    chk({7'h00, cfg_open}, 8'h01, "key pair");
  endtask
  // enable lives in its own bank and is set by read-modify-write
  task automatic t_enable();
    logic [7:0] d;
    logic       ok;
    host.en_gpio(d, ok);
    chk((ok === 1'b1) ? d : 8'hEE, RST_FUNC_EN, "enable reset");
    rdchk(REG_FUNC_EN, 8'h80, "enable bit");
    rdchk(REG_DIR, RD_UNMAPPED, "wrong bank");
    host.put(LDN_INDEX, LDN_GPIO);
    rdchk(REG_DIR, RST_DIR, "dir reset");
    rdchk(REG_INV, RST_INV, "inv reset");
    chk(goe, 8'h00, "inputs undriven");
  endtask
  // low nibble driven, high nibble sensed, under a given inversion mask
  task automatic t_pins(input logic [7:0] inv);
    host.put(REG_DIR, 8'hF0);
    host.put(REG_INV, inv);
    host.put(REG_DATA, 8'hA5);
    pin = 8'h3C ^ inv;
    repeat (4) @(negedge clk);
    chk(goe, 8'h0F, "drive mask");
    chk(gout, 8'h05 ^ inv, "pin out");
    rdchk(REG_DATA, (8'hF0 & (pin ^ inv)) | 8'h05, "data read");
    rdchk(REG_INV, inv, "inv read");
  endtask
  // relock keeps state and refuses access until the keys come again
  task automatic t_exit();
    logic [7:0] d;
    logic       ok;
    host.put(REG_DIR, 8'h00);
    rdchk(REG_DATA, 8'h05, "input writes kept out");
    host.wr(CFG_INDEX_PORT, KEY_EXIT);
    repeat (2) @(negedge clk);
    chk({7'h00, cfg_open}, 8'h00, "relocked");
    host.put(REG_DATA, 8'h00);
    rdchk(REG_DATA, RD_LOCKED, "locked data");
    host.unlock();
    rdchk(REG_DATA, 8'h05, "kept while locked");
    host.rd(CFG_INDEX_PORT, d, ok);
    chk((ok === 1'b1) ? d : 8'h00, REG_DATA, "index read back");
    chk(goe, 8'hFF, "all driven");
  endtask
  // reset, then the scenarios in order
  initial
  begin
    rst_b = 1'b0;
    pin = 8'h00;
    err_total = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    t_keys();
    t_enable();
    t_pins(8'h00);
    t_pins(8'hFF);
    t_exit();
    conclude();
  end
endmodule

`default_nettype wire
